// ===== bench/flash_array_model.sv
// flash array and config area model for the flash controller bench
// assumes the controller strobes read and write one word a cycle and erase one whole row a cycle
module flash_array_model (
  // clock
  input wire logic clk_in,
  // array side
  input wire logic [14:0] addr_in,
  input wire logic region_in,
  input wire logic rd_in,
  input wire logic we_in,
  input wire logic [13:0] wdata_in,
  input wire logic erase_in,
  output logic [13:0] rdata_out,
  output logic protected_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [0:32767];
  logic [13:0] last;
  int we_count;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 14'h0000;
    last = 14'h0000;
    we_count = 0;
  end
  // upper half of program flash is write protected
  assign protected_out = addr_in[14] & ~region_in;
  // idle read bus shows inverted data so stale words never match
  assign rdata_out = !rd_in ? ~last :
    region_in ? (addr_in[13:0] ^ 14'h2aaa) : mem[addr_in];
  always @(posedge clk_in) begin
    if (rd_in) last <= rdata_out;
    if (we_in) begin
      mem[addr_in] <= wdata_in;
      we_count++;
    end
    if (erase_in) begin
      for (int i = 0; i < 32; i++) mem[{addr_in[14:5], i[4:0]}] <= 14'h3fff;
    end
  end
endmodule : flash_array_model

// ===== bench/tb_top.sv
// self-checking bench for the flash controller, apb master side
// assumes the array model answers reads in the strobe cycle
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_ADR = {2'b00, flash_ctrl_pkg::IDX_ADDRESS, 2'b00};
  localparam logic [15:0] A_DAT = {2'b00, flash_ctrl_pkg::IDX_DATA, 2'b00};
  localparam logic [15:0] A_CTL = {2'b00, flash_ctrl_pkg::IDX_CONTROL, 2'b00};
  localparam logic [15:0] A_KEY = {2'b00, flash_ctrl_pkg::IDX_UNLOCK, 2'b00};
  logic clk = 1'b0, rst_n = 1'b0, warm = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, slv, f_rd, f_we, f_er, f_reg, f_prot;
  logic [14:0] f_addr;
  logic [13:0] f_rdata, f_wdata;
  int fail_count = 0, n_tests = 0, base;
  `define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    fail_count++; $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end end
  always #5 clk = ~clk;
  nvm_program_flash_control #(.ERASE_CYCLES(40), .WRITE_CYCLES(40)) dut_u (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n), .WARM_RESET_IN(warm),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FLASH_ADDR_OUT(f_addr),
    .FLASH_REGION_OUT(f_reg), .FLASH_RD_OUT(f_rd), .FLASH_RDATA_IN(f_rdata),
    .FLASH_WE_OUT(f_we), .FLASH_WDATA_OUT(f_wdata), .FLASH_ERASE_OUT(f_er),
    .FLASH_PROTECTED_IN(f_prot));
  flash_array_model arr_u (.clk_in(clk), .addr_in(f_addr), .region_in(f_reg),
    .rd_in(f_rd), .we_in(f_we), .wdata_in(f_wdata), .erase_in(f_er),
    .rdata_out(f_rdata), .protected_out(f_prot));
  // ----------------------------------------
  // apb master tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic start(input logic [31:0] ctl);
    apb(1'b1, A_KEY, 32'h00000055);
    apb(1'b1, A_KEY, 32'h000000aa);
    apb(1'b1, A_CTL, ctl);
  endtask : start
  task automatic wait_idle();
    do apb(1'b0, A_CTL, 32'h0); while (q[1] !== 1'b0);
  endtask : wait_idle
  task automatic read_word(input logic [14:0] a, input logic reg_sel);
    apb(1'b1, A_ADR, {17'h0, a});
    apb(1'b1, A_CTL, {25'h0, reg_sel, 6'h01});
    apb(1'b0, A_DAT, 32'h0);
  endtask : read_word
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, A_CTL, 32'h0);
    `CHK("ctl reset", 32'h0, q)
    apb(1'b0, A_KEY, 32'h0);
    `CHK("unlock read", 32'h0, q)
    apb(1'b0, 16'h2000, 32'h0);
    `CHK("unmapped err", 1'b1, slv)
    for (int k = 0; k < 32; k++) begin
      apb(1'b1, A_ADR, 32'h40 + k);
      apb(1'b1, A_DAT, (k * 32'h111) & 32'h3fff);
      start(32'h26);
      wait_idle();
    end
    `CHK("latch strobes", 0, arr_u.we_count)
    apb(1'b1, A_ADR, 32'h45);
    start(32'h06);
    wait_idle();
    `CHK("row strobes", 32, arr_u.we_count)
    for (int k = 0; k < 32; k++) begin
      read_word(15'h40 + k[14:0], 1'b0);
      `CHK("row word", (k * 32'h111) & 32'h3fff, q)
    end
    apb(1'b0, A_CTL, 32'h0);
    `CHK("rd cleared", 1'b0, q[0])
    start(32'h06);
    wait_idle();
    read_word(15'h43, 1'b0);
    `CHK("latch reset", 32'h3fff, q)
    base = arr_u.we_count;
    apb(1'b1, A_ADR, 32'h27);
    start(32'h36);
    apb(1'b1, A_CTL, 32'h04);
    apb(1'b0, A_CTL, 32'h0);
    `CHK("wr held", 1'b1, q[1])
    wait_idle();
    read_word(15'h20, 1'b0);
    `CHK("row erased", 32'h3fff, q)
    read_word(15'h3f, 1'b0);
    `CHK("row end erased", 32'h3fff, q)
    `CHK("erase no we", base, arr_u.we_count)
    read_word(15'h123, 1'b1);
    `CHK("config read", 32'h123 ^ 32'h2aaa, q)
    apb(1'b1, A_KEY, 32'h55);
    apb(1'b1, A_ADR, 32'h0);
    apb(1'b0, A_CTL, 32'h0);
    `CHK("broken unlock", 1'b1, q[3])
    apb(1'b1, A_CTL, 32'h0e);
    apb(1'b0, A_CTL, 32'h0);
    `CHK("no start", 1'b0, q[1])
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b0, A_CTL, 32'h0);
    `CHK("err cleared", 1'b0, q[3])
    apb(1'b1, A_CTL, 32'h08);
    apb(1'b0, A_CTL, 32'h0);
    `CHK("err set by sw", 1'b1, q[3])
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_ADR, 32'h4000);
    start(32'h06);
    apb(1'b0, A_CTL, 32'h0);
    `CHK("prot start", 2'b10, {q[3], q[1]})
    `CHK("prot no we", base, arr_u.we_count)
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_ADR, 32'h60);
    start(32'h12);
    wait_idle();
    read_word(15'h60, 1'b0);
    `CHK("no erase off", 32'h0, q)
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_ADR, 32'h60);
    start(32'h16);
    @(posedge clk) warm <= 1'b1;
    @(posedge clk) warm <= 1'b0;
    wait_idle();
    `CHK("warm reset err", 1'b1, q[3])
    tally_and_finish();
  end
endmodule : tb_top

// ===== design/nvm_program_flash_control.sv
// flash self-programming controller with APB register access
// assumes an asynchronous read array and a write-protect flag that
// tracks the address shown on the flash address port
//
// Contract
// - erase 0, latch-only 1: write start only loads one row latch
// - erase 0, latch-only 0 programs the row; erase 1 ignores latch-only
// - erase 1 erases the whole 32-word row to all ones
// - erase 0 never erases before writing
// - error flag set on warm reset mid-write, broken unlock, protected start
// - hardware never clears the error flag; software clears it
// - software may write the error flag to one and it stays set
// - no program or erase starts unless the start write sets program/erase enable
// - write start launches a self-timed operation, cleared at the end
// - writing zero to write start during an operation does nothing
// - write start accepted only right after 0x55 then 0xaa unlock
// - read start loads data from the address, then clears itself
// - read start can be set but not cleared by software
// - error flag read back is undefined while write start is set
// - unlock register is 8-bit write-only and reads as zero
// - protected erase or row write: start cleared, error flag set
// - after a row write all latches return to all ones
// - latch loads ignore protection and never touch the array
// - region select 0 targets program flash, 1 the config area
//
// Register access over APB was decided locally.
module nvm_program_flash_control #(
  parameter int ERASE_CYCLES = flash_ctrl_pkg::ERASE_CYCLES,
  parameter int WRITE_CYCLES = flash_ctrl_pkg::WRITE_CYCLES
) (
  // clock and resets
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic WARM_RESET_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // flash array
  output logic [14:0] FLASH_ADDR_OUT,
  output logic FLASH_REGION_OUT,
  output logic FLASH_RD_OUT,
  input wire logic [13:0] FLASH_RDATA_IN,
  output logic FLASH_WE_OUT,
  output logic [13:0] FLASH_WDATA_OUT,
  output logic FLASH_ERASE_OUT,
  input wire logic FLASH_PROTECTED_IN
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // one-hot select: address, data, control, unlock
  function automatic logic [3:0] decode(input logic [15:0] a);
    logic [11:0] idx;
    idx = {2'b00, a[11:2]};
    if (a[1:0] != 2'b00 || a[15:14] != 2'b00) begin
      decode = 4'h0;
    end else begin
      idx = a[13:2];
      decode = {idx == flash_ctrl_pkg::IDX_UNLOCK,
                idx == flash_ctrl_pkg::IDX_CONTROL,
                idx == flash_ctrl_pkg::IDX_DATA,
                idx == flash_ctrl_pkg::IDX_ADDRESS};
    end
  endfunction : decode

  logic [3:0] sel;
  logic acc_wr;
  logic acc_setup;
  assign sel = decode(PADDR_IN);
  assign acc_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign acc_setup = PSEL_IN & ~PENABLE_IN;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  flash_ctrl_pkg::op_state_t state_r, state_nxt;
  flash_ctrl_pkg::unlock_state_t unlock_r, unlock_nxt;
  logic [14:0] addr_r, addr_nxt;
  logic [13:0] data_r, data_nxt;
  logic region_r, region_nxt;
  logic latch_only_r, latch_only_nxt;
  logic erase_r, erase_nxt;
  logic error_r, error_nxt;
  logic enable_r, enable_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic [14:0] op_addr_r, op_addr_nxt;
  logic op_region_r, op_region_nxt;
  logic [flash_ctrl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [14:0] fl_addr_r, fl_addr_nxt;
  logic fl_region_r, fl_region_nxt;
  logic fl_rd_r, fl_rd_nxt;
  logic fl_we_r, fl_we_nxt;
  logic [13:0] fl_wdata_r, fl_wdata_nxt;
  logic fl_erase_r, fl_erase_nxt;
  logic latch_load, latch_clear, hw_error, start_ok;
  logic [4:0] latch_rd_idx;
  logic [13:0] latch_rd_data;
  logic [7:0] ctrl_word;

  localparam logic [flash_ctrl_pkg::CNT_W-1:0] ERASE_LAST =
    flash_ctrl_pkg::CNT_W'(ERASE_CYCLES - 1);
  localparam logic [flash_ctrl_pkg::CNT_W-1:0] WRITE_LAST =
    flash_ctrl_pkg::CNT_W'(WRITE_CYCLES - 1);
  localparam logic [flash_ctrl_pkg::CNT_W-1:0] ROW_LAST =
    flash_ctrl_pkg::CNT_W'(flash_ctrl_pkg::ROW_WORDS - 1);

  assign ctrl_word = {1'b0, region_r, latch_only_r, erase_r, error_r,
                      enable_r, wr_r, rd_r};

  row_latch_bank u_latch (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .load_in(latch_load),
    .load_idx_in(op_addr_r[4:0]),
    .load_data_in(data_r),
    .clear_in(latch_clear),
    .rd_idx_in(latch_rd_idx),
    .rd_data_out(latch_rd_data)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unlock_nxt = unlock_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    region_nxt = region_r;
    latch_only_nxt = latch_only_r;
    erase_nxt = erase_r;
    error_nxt = error_r;
    enable_nxt = enable_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    op_addr_nxt = op_addr_r;
    op_region_nxt = op_region_r;
    cnt_nxt = cnt_r;
    fl_addr_nxt = addr_r;
    fl_region_nxt = region_r;
    fl_rd_nxt = 1'b0;
    fl_we_nxt = 1'b0;
    fl_erase_nxt = 1'b0;
    latch_load = 1'b0;
    latch_clear = 1'b0;
    latch_rd_idx = 5'h00;
    hw_error = 1'b0;
    start_ok = 1'b0;

    // apb answers one cycle after setup, no wait states
    pready_nxt = acc_setup;
    pslverr_nxt = acc_setup & (sel == 4'h0);
    prdata_nxt = 32'h0000_0000;
    unique case (1'b1)
      sel[0]: prdata_nxt = {17'h00000, addr_r};
      sel[1]: prdata_nxt = {18'h00000, data_r};
      sel[2]: prdata_nxt = {24'h000000, ctrl_word};
      default: prdata_nxt = 32'h0000_0000;
    endcase

    // unlock tracking: 0x55, 0xaa, then the control write
    if (acc_wr && sel != 4'h0) begin
      unique case (unlock_r)
        flash_ctrl_pkg::UL_LOCKED: begin
          if (sel[3] && PWDATA_IN[7:0] == flash_ctrl_pkg::KEY_FIRST) begin
            unlock_nxt = flash_ctrl_pkg::UL_FIRST;
          end
        end
        flash_ctrl_pkg::UL_FIRST: begin
          if (sel[3] && PWDATA_IN[7:0] == flash_ctrl_pkg::KEY_SECOND) begin
            unlock_nxt = flash_ctrl_pkg::UL_OPEN;
          end else begin
            unlock_nxt = flash_ctrl_pkg::UL_LOCKED;
            hw_error = 1'b1;
          end
        end
        flash_ctrl_pkg::UL_OPEN: begin
          unlock_nxt = flash_ctrl_pkg::UL_LOCKED;
          if (sel[2] && PWDATA_IN[flash_ctrl_pkg::BIT_WR]) begin
            start_ok = 1'b1;
          end else begin
            hw_error = 1'b1;
          end
        end
      endcase
    end

    // plain register writes
    if (acc_wr && sel[0]) begin
      addr_nxt = PWDATA_IN[14:0];
    end
    if (acc_wr && sel[1]) begin
      data_nxt = PWDATA_IN[13:0];
    end
    if (acc_wr && sel[2]) begin
      region_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_REGION];
      latch_only_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_LATCH_ONLY];
      erase_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_ERASE];
      enable_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_ENABLE];
      error_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_ERROR];
      // write start is left to the sequencer, so a zero is dropped
      // zeros written to the start bits are dropped
      if (PWDATA_IN[flash_ctrl_pkg::BIT_RD] && state_r ==
          flash_ctrl_pkg::ST_IDLE && !wr_r && !start_ok) begin
        rd_nxt = 1'b1;
        fl_rd_nxt = 1'b1;
        // region comes with the read word, not the stale register
        fl_region_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_REGION];
        state_nxt = flash_ctrl_pkg::ST_READ;
      end
    end

    // operation sequencer
    unique case (state_r)
      flash_ctrl_pkg::ST_IDLE: begin
        // enable is taken from the same write that sets start
        if (start_ok && !wr_r &&
            PWDATA_IN[flash_ctrl_pkg::BIT_ENABLE]) begin
          op_addr_nxt = addr_r;
          op_region_nxt = PWDATA_IN[flash_ctrl_pkg::BIT_REGION];
          cnt_nxt = '0;
          if (!PWDATA_IN[flash_ctrl_pkg::BIT_ERASE] &&
              PWDATA_IN[flash_ctrl_pkg::BIT_LATCH_ONLY]) begin
            wr_nxt = 1'b1;
            state_nxt = flash_ctrl_pkg::ST_LATCH;
          end else if (FLASH_PROTECTED_IN) begin
            hw_error = 1'b1;
          end else if (PWDATA_IN[flash_ctrl_pkg::BIT_ERASE]) begin
            wr_nxt = 1'b1;
            state_nxt = flash_ctrl_pkg::ST_ERASE;
          end else begin
            wr_nxt = 1'b1;
            state_nxt = flash_ctrl_pkg::ST_PROG;
          end
        end
      end
      flash_ctrl_pkg::ST_READ: begin
        // array answers while the read strobe is shown
        data_nxt = FLASH_RDATA_IN;
        rd_nxt = 1'b0;
        state_nxt = flash_ctrl_pkg::ST_IDLE;
      end
      flash_ctrl_pkg::ST_LATCH: begin
        latch_load = 1'b1;
        wr_nxt = 1'b0;
        state_nxt = flash_ctrl_pkg::ST_IDLE;
      end
      flash_ctrl_pkg::ST_ERASE: begin
        fl_addr_nxt = {op_addr_r[14:5], 5'h00};
        fl_region_nxt = op_region_r;
        fl_erase_nxt = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == ERASE_LAST) begin
          fl_erase_nxt = 1'b0;
          wr_nxt = 1'b0;
          state_nxt = flash_ctrl_pkg::ST_IDLE;
        end
      end
      flash_ctrl_pkg::ST_PROG: begin
        fl_region_nxt = op_region_r;
        fl_addr_nxt = {op_addr_r[14:5], 5'h00};
        latch_rd_idx = cnt_r[4:0];
        // one word per cycle, then hold for the rest of the time
        if (cnt_r <= ROW_LAST) begin
          fl_addr_nxt = {op_addr_r[14:5], cnt_r[4:0]};
          fl_we_nxt = 1'b1;
        end
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == WRITE_LAST) begin
          latch_clear = 1'b1;
          wr_nxt = 1'b0;
          state_nxt = flash_ctrl_pkg::ST_IDLE;
        end
      end
    endcase
    fl_wdata_nxt = latch_rd_data;

    // set wins over a software clear in the same cycle
    if (hw_error) begin
      error_nxt = 1'b1;
    end

    // warm reset aborts everything; a cut write leaves the flag set
    if (WARM_RESET_IN) begin
      if (state_r == flash_ctrl_pkg::ST_ERASE ||
          state_r == flash_ctrl_pkg::ST_PROG) begin
        error_nxt = 1'b1;
      end
      state_nxt = flash_ctrl_pkg::ST_IDLE;
      unlock_nxt = flash_ctrl_pkg::UL_LOCKED;
      addr_nxt = flash_ctrl_pkg::ADDR_RESET;
      region_nxt = 1'b0;
      latch_only_nxt = 1'b0;
      erase_nxt = 1'b0;
      enable_nxt = 1'b0;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
      fl_addr_nxt = flash_ctrl_pkg::ADDR_RESET;
      fl_region_nxt = 1'b0;
      fl_rd_nxt = 1'b0;
      fl_we_nxt = 1'b0;
      fl_erase_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r <= flash_ctrl_pkg::ST_IDLE;
      unlock_r <= flash_ctrl_pkg::UL_LOCKED;
      addr_r <= flash_ctrl_pkg::ADDR_RESET;
      data_r <= 14'h0000;
      region_r <= 1'b0;
      latch_only_r <= 1'b0;
      erase_r <= 1'b0;
      error_r <= 1'b0;
      enable_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      op_addr_r <= flash_ctrl_pkg::ADDR_RESET;
      op_region_r <= 1'b0;
      cnt_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      fl_addr_r <= flash_ctrl_pkg::ADDR_RESET;
      fl_region_r <= 1'b0;
      fl_rd_r <= 1'b0;
      fl_we_r <= 1'b0;
      fl_wdata_r <= flash_ctrl_pkg::LATCH_ERASED;
      fl_erase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      unlock_r <= unlock_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      region_r <= region_nxt;
      latch_only_r <= latch_only_nxt;
      erase_r <= erase_nxt;
      error_r <= error_nxt;
      enable_r <= enable_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      op_addr_r <= op_addr_nxt;
      op_region_r <= op_region_nxt;
      cnt_r <= cnt_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      fl_addr_r <= fl_addr_nxt;
      fl_region_r <= fl_region_nxt;
      fl_rd_r <= fl_rd_nxt;
      fl_we_r <= fl_we_nxt;
      fl_wdata_r <= fl_wdata_nxt;
      fl_erase_r <= fl_erase_nxt;
    end
  end

  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign FLASH_ADDR_OUT = fl_addr_r;
  assign FLASH_REGION_OUT = fl_region_r;
  assign FLASH_RD_OUT = fl_rd_r;
  assign FLASH_WE_OUT = fl_we_r;
  assign FLASH_WDATA_OUT = fl_wdata_r;
  assign FLASH_ERASE_OUT = fl_erase_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_rd_self_clear;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $rose(rd_r) |-> FLASH_RD_OUT ##1 !rd_r;
  endproperty
  a_rd_self_clear: assert property (p_rd_self_clear)
    else $error("read start did not clear after one cycle");

  property p_wr_needs_unlock;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $rose(wr_r) |-> $past(unlock_r) == flash_ctrl_pkg::UL_OPEN;
  endproperty
  a_wr_needs_unlock: assert property (p_wr_needs_unlock)
    else $error("write start set without unlock");

  property p_wr_needs_enable;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $rose(wr_r) |-> enable_r;
  endproperty
  a_wr_needs_enable: assert property (p_wr_needs_enable)
    else $error("write start set while disabled");

  property p_array_only_busy;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    (FLASH_WE_OUT || FLASH_ERASE_OUT) |-> $past(wr_r) && wr_r;
  endproperty
  a_array_only_busy: assert property (p_array_only_busy)
    else $error("array cycle outside an operation");

  property p_error_sticky;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    error_r && !(acc_wr && sel[2]) |=> error_r;
  endproperty
  a_error_sticky: assert property (p_error_sticky)
    else $error("error flag cleared by hardware");

  property p_latch_no_array;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    state_r == flash_ctrl_pkg::ST_LATCH |=>
      !FLASH_WE_OUT && !FLASH_ERASE_OUT && !wr_r;
  endproperty
  a_latch_no_array: assert property (p_latch_no_array)
    else $error("latch load touched the array");

  property p_protected_refused;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    start_ok && FLASH_PROTECTED_IN && !WARM_RESET_IN &&
      state_r == flash_ctrl_pkg::ST_IDLE && !wr_r && enable_nxt &&
      !(latch_only_nxt && !erase_nxt)
      |=> error_r && !wr_r ##1 !FLASH_WE_OUT && !FLASH_ERASE_OUT;
  endproperty
  a_protected_refused: assert property (p_protected_refused)
    else $error("protected start was not refused");

  property p_wr_clears_only_at_end;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $fell(wr_r) |-> $past(state_r) == flash_ctrl_pkg::ST_LATCH ||
      $past(cnt_r) == ERASE_LAST || $past(cnt_r) == WRITE_LAST ||
      $past(WARM_RESET_IN);
  endproperty
  a_wr_clears_only_at_end: assert property (p_wr_clears_only_at_end)
    else $error("write start dropped before completion");

  property p_erase_row_aligned;
    @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    FLASH_ERASE_OUT |-> FLASH_ADDR_OUT[4:0] == 5'h00 && !FLASH_WE_OUT;
  endproperty
  a_erase_row_aligned: assert property (p_erase_row_aligned)
    else $error("erase not aimed at a row start");

endmodule : nvm_program_flash_control

// ===== design/row_latch_bank.sv
// row write latches: one word per row position, cleared as a whole
// assumes write and clear never come in the same cycle
module row_latch_bank #(
  parameter int WORDS = flash_ctrl_pkg::ROW_WORDS,
  parameter int IDX_W = flash_ctrl_pkg::ROW_BITS,
  parameter int DATA_W = flash_ctrl_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // load port
  input wire logic load_in,
  input wire logic [IDX_W-1:0] load_idx_in,
  input wire logic [DATA_W-1:0] load_data_in,
  input wire logic clear_in,
  // read port
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] latch_r [WORDS];

  assign rd_data_out = latch_r[rd_idx_in];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < WORDS; i++) begin
        latch_r[i] <= flash_ctrl_pkg::LATCH_ERASED;
      end
    end else if (clear_in) begin
      for (int i = 0; i < WORDS; i++) begin
        latch_r[i] <= flash_ctrl_pkg::LATCH_ERASED;
      end
    end else if (load_in) begin
      latch_r[load_idx_in] <= load_data_in;
    end
  end

endmodule : row_latch_bank

// ===== pkg/flash_ctrl_pkg.sv
// constants for the flash self-programming controller
// assumes one 100 MHz clock; registers sit on 32-bit APB words
package flash_ctrl_pkg;

  // -------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -------------------------------------------------------------
  localparam logic [11:0] IDX_ADDRESS = 12'h81a;
  localparam logic [11:0] IDX_DATA = 12'h81c;
  localparam logic [11:0] IDX_CONTROL = 12'h81e;
  localparam logic [11:0] IDX_UNLOCK = 12'h81f;

  // -------------------------------------------------------------
  // control register fields
  // -------------------------------------------------------------
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_ENABLE = 2;
  localparam int BIT_ERROR = 3;
  localparam int BIT_ERASE = 4;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_REGION = 6;

  // -------------------------------------------------------------
  // widths, reset values, unlock pattern
  // -------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam int ROW_BITS = 5;
  localparam int ROW_WORDS = 32;
  localparam int CNT_W = 24;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [13:0] LATCH_ERASED = 14'h3fff;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // -------------------------------------------------------------
  // timing: least times, rounded up to whole cycles
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_NS = 2000000;
  localparam int WRITE_TIME_NS = 2000000;
  localparam int ERASE_CYCLES =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -------------------------------------------------------------
  // state encodings
  // -------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_LATCH = 5'b00100,
    ST_ERASE = 5'b01000,
    ST_PROG = 5'b10000
  } op_state_t;

  typedef enum logic [2:0] {
    UL_LOCKED = 3'b001,
    UL_FIRST = 3'b010,
    UL_OPEN = 3'b100
  } unlock_state_t;

endpackage : flash_ctrl_pkg
